// ### design/lgap_defines.svh
`ifndef LGAP_DEFINES_SVH
`define LGAP_DEFINES_SVH

// i/o window
`define LGAP_ADDR_BITS 10
`define LGAP_WIN_BITS 4
`define LGAP_OFS_FM_LEFT_IDX 4'h0
`define LGAP_OFS_FM_LEFT_DATA 4'h1
`define LGAP_OFS_FM_RIGHT_IDX 4'h2
`define LGAP_OFS_FM_RIGHT_DATA 4'h3
`define LGAP_OFS_MIX_INDEX 4'h4
`define LGAP_OFS_MIX_DATA 4'h5
`define LGAP_OFS_IF_RESET 4'h6
`define LGAP_OFS_FM_IDX 4'h8
`define LGAP_OFS_FM_DATA 4'h9
`define LGAP_OFS_READ_DATA 4'hA
`define LGAP_OFS_CMD 4'hC
`define LGAP_OFS_AVAIL 4'hE

// mixer indices
`define LGAP_MIX_RESET 8'h00
`define LGAP_MIX_VOICE 8'h04
`define LGAP_MIX_MIC 8'h0A
`define LGAP_MIX_INSEL 8'h0C
`define LGAP_MIX_OUTCTL 8'h0E
`define LGAP_MIX_MASTER 8'h22
`define LGAP_MIX_FM 8'h26
`define LGAP_MIX_CD 8'h28
`define LGAP_MIX_LINE 8'h2E

// mixer reset values
`define LGAP_RST_VOICE 8'h99
`define LGAP_RST_MIC 8'h01
`define LGAP_RST_INSEL 8'h00
`define LGAP_RST_OUTCTL 8'h00
`define LGAP_RST_MASTER 8'h99
`define LGAP_RST_FM 8'h99
`define LGAP_RST_CD 8'h01
`define LGAP_RST_LINE 8'h01

// fields and constants
`define LGAP_MIC_MASK 8'h07
`define LGAP_INSEL_MASK 8'h06
`define LGAP_OUTCTL_MASK 8'h02
`define LGAP_STEREO_BIT 1
`define LGAP_INSEL_LO 1
`define LGAP_SWRST_BIT 0
`define LGAP_FLAG_BIT 7
`define LGAP_RSVD_READ 8'hFF
`define LGAP_IDLE_READ 8'hFF

`endif

// ### design/lgap_pkg.sv
package lgap_pkg;

  typedef enum logic [1:0] {
    LGAP_SRC_MIC,
    LGAP_SRC_CD,
    LGAP_SRC_MIC2,
    LGAP_SRC_LINE
  } lgap_src_e;

  typedef enum logic {
    LGAP_MODE_OTHER,
    LGAP_MODE_LEGACY
  } lgap_mode_e;

  typedef enum logic [1:0] {
    LGAP_RST_IDLE,
    LGAP_RST_ARMED,
    LGAP_RST_FIRE
  } lgap_rst_e;

  typedef struct packed {
    logic [7:0] voice;
    logic [7:0] mic;
    logic [7:0] inSel;
    logic [7:0] outCtl;
    logic [7:0] master;
    logic [7:0] fm;
    logic [7:0] cd;
    logic [7:0] line;
  } lgap_mixer_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] data;
  } lgap_req_s;

  typedef struct packed {
    logic legacySel;
    logic rd;
    logic wr;
    logic [1:0] port;
    logic [7:0] data;
  } lgap_fm_s;

endpackage

// ### design/lgap_mixer.sv
`timescale 1ns/10ps
`include "lgap_defines.svh"

module lgap_mixer
  import lgap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access
  input wire logic clearAll,
  input wire logic wrEn,
  input wire logic [7:0] index,
  input wire logic [7:0] wrData,
  // state
  output lgap_mixer_s mixer,
  output logic [7:0] rdData
);

  typedef struct packed {
    lgap_mixer_s mix;
  } lgap_mixst_s;

  lgap_mixst_s st;
  lgap_mixst_s next_st;

  function automatic lgap_mixer_s lgap_defaults();
    lgap_mixer_s m;
    m.voice = `LGAP_RST_VOICE;
    m.mic = `LGAP_RST_MIC;
    m.inSel = `LGAP_RST_INSEL;
    m.outCtl = `LGAP_RST_OUTCTL;
    m.master = `LGAP_RST_MASTER;
    m.fm = `LGAP_RST_FM;
    m.cd = `LGAP_RST_CD;
    m.line = `LGAP_RST_LINE;
    return m;
  endfunction

  // =====================================
  // register update
  always_comb begin
    next_st = st;
    if (clearAll || (wrEn && index == `LGAP_MIX_RESET)) begin
      next_st.mix = lgap_defaults();
    end else if (wrEn) begin
      case (index)
        `LGAP_MIX_VOICE: next_st.mix.voice = wrData;
        `LGAP_MIX_MIC: next_st.mix.mic = wrData & `LGAP_MIC_MASK;
        `LGAP_MIX_INSEL: next_st.mix.inSel = wrData & `LGAP_INSEL_MASK;
        `LGAP_MIX_OUTCTL: next_st.mix.outCtl = wrData & `LGAP_OUTCTL_MASK;
        `LGAP_MIX_MASTER: next_st.mix.master = wrData;
        `LGAP_MIX_FM: next_st.mix.fm = wrData;
        `LGAP_MIX_CD: next_st.mix.cd = wrData;
        `LGAP_MIX_LINE: next_st.mix.line = wrData;
        default: next_st = st;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.mix <= {`LGAP_RST_VOICE, `LGAP_RST_MIC, `LGAP_RST_INSEL, `LGAP_RST_OUTCTL,
                 `LGAP_RST_MASTER, `LGAP_RST_FM, `LGAP_RST_CD, `LGAP_RST_LINE};
    end else begin
      st <= next_st;
    end
  end

  assign mixer = st.mix;

  // =====================================
  // read mux
  always_comb begin
    case (index)
      `LGAP_MIX_VOICE: rdData = st.mix.voice;
      `LGAP_MIX_MIC: rdData = st.mix.mic;
      `LGAP_MIX_INSEL: rdData = st.mix.inSel;
      `LGAP_MIX_OUTCTL: rdData = st.mix.outCtl;
      `LGAP_MIX_MASTER: rdData = st.mix.master;
      `LGAP_MIX_FM: rdData = st.mix.fm;
      `LGAP_MIX_CD: rdData = st.mix.cd;
      `LGAP_MIX_LINE: rdData = st.mix.line;
      default: rdData = `LGAP_RSVD_READ;
    endcase
  end

endmodule

// ### design/lgap_regs.sv
`timescale 1ns/10ps
`include "lgap_defines.svh"

module lgap_regs
  import lgap_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host i/o bus
  input wire logic [ADDR_W-1:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  // plug and play base
  input wire logic [`LGAP_ADDR_BITS-1:0] legacyPortBase,
  input wire logic legacyEnable,
  // synthesizer side
  output lgap_fm_s fmReq,
  input wire logic [7:0] fmStatus,
  // command engine side
  output lgap_req_s cmdOut,
  input wire logic cmdTaken,
  input wire logic rdDataLoad,
  input wire logic [7:0] rdDataIn,
  output logic rdDataTaken,
  // mode and shared resources
  input wire logic otherCodecActive,
  input wire logic codecIrqReq,
  input wire logic codecDmaReq,
  output logic legacyGameAudioMode,
  output logic sharedIrq,
  output logic sharedDmaReq,
  // mixer settings
  output lgap_mixer_s mixerState,
  output lgap_src_e adcSource,
  output logic stereoSelect,
  // interface reset pulse
  output logic ifResetPulse
);

  typedef struct packed {
    logic [7:0] mixIndex;
    lgap_rst_e rstState;
    logic ifReset;
    logic cmdBusy;
    lgap_req_s cmd;
    logic [7:0] readData;
    logic dataAvail;
    logic rdTaken;
    lgap_fm_s fm;
    logic [7:0] rdOut;
    logic rdValid;
    lgap_mode_e mode;
    logic irq;
    logic dma;
  } lgap_state_s;

  lgap_state_s st;
  lgap_state_s next_st;

  logic hit;
  logic [`LGAP_WIN_BITS-1:0] ofs;
  logic mixWr;
  logic [7:0] mixRd;
  lgap_mixer_s mixer;

  // =====================================
  // address decode
  // upper bits zero, no alias
  always_comb begin
    ofs = ioAddr[`LGAP_WIN_BITS-1:0];
    hit = legacyEnable
      && (ioAddr[ADDR_W-1:`LGAP_ADDR_BITS] == '0)
      && (ioAddr[`LGAP_ADDR_BITS-1:`LGAP_WIN_BITS]
          == legacyPortBase[`LGAP_ADDR_BITS-1:`LGAP_WIN_BITS]);
  end

  assign mixWr = hit && ioWr && ofs == `LGAP_OFS_MIX_DATA;

  lgap_mixer u_mixer (
    .clk(clk),
    .rst_n(rst_n),
    .clearAll(st.ifReset),
    .wrEn(mixWr),
    .index(st.mixIndex),
    .wrData(ioWrData),
    .mixer(mixer),
    .rdData(mixRd)
  );

  // =====================================
  // next state
  always_comb begin
    next_st = st;
    next_st.fm.rd = 1'b0;
    next_st.fm.wr = 1'b0;
    next_st.rdValid = 1'b0;
    next_st.rdTaken = 1'b0;
    next_st.ifReset = 1'b0;

    if (cmdTaken) begin
      next_st.cmd.valid = 1'b0;
      next_st.cmdBusy = 1'b0;
    end
    if (rdDataLoad) begin
      next_st.readData = rdDataIn;
      next_st.dataAvail = 1'b1;
    end

    if (hit && ioWr) begin
      case (ofs)
        `LGAP_OFS_FM_LEFT_IDX, `LGAP_OFS_FM_LEFT_DATA,
        `LGAP_OFS_FM_RIGHT_IDX, `LGAP_OFS_FM_RIGHT_DATA: begin
          next_st.fm.wr = 1'b1;
          next_st.fm.legacySel = 1'b0;
          next_st.fm.port = ofs[1:0];
          next_st.fm.data = ioWrData;
        end
        `LGAP_OFS_FM_IDX, `LGAP_OFS_FM_DATA: begin
          next_st.fm.wr = 1'b1;
          next_st.fm.legacySel = 1'b1;
          next_st.fm.port = ofs[1:0];
          next_st.fm.data = ioWrData;
        end
        `LGAP_OFS_MIX_INDEX: next_st.mixIndex = ioWrData;
        `LGAP_OFS_IF_RESET: begin
          if (ioWrData[`LGAP_SWRST_BIT]) begin
            next_st.rstState = LGAP_RST_ARMED;
          end else if (st.rstState == LGAP_RST_ARMED) begin
            next_st.rstState = LGAP_RST_IDLE;
            next_st.ifReset = 1'b1;
          end
        end
        `LGAP_OFS_CMD: begin
          if (!st.cmdBusy) begin
            next_st.cmd.valid = 1'b1;
            next_st.cmd.write = 1'b1;
            next_st.cmd.data = ioWrData;
            next_st.cmdBusy = 1'b1;
          end
        end
        default: next_st.fm.wr = 1'b0;
      endcase
    end

    if (hit && ioRd) begin
      next_st.rdValid = 1'b1;
      case (ofs)
        `LGAP_OFS_FM_LEFT_IDX, `LGAP_OFS_FM_RIGHT_IDX, `LGAP_OFS_FM_IDX: begin
          next_st.fm.rd = 1'b1;
          next_st.fm.legacySel = (ofs == `LGAP_OFS_FM_IDX);
          next_st.fm.port = ofs[1:0];
          next_st.rdOut = fmStatus;
        end
        `LGAP_OFS_MIX_DATA: next_st.rdOut = mixRd;
        `LGAP_OFS_READ_DATA: begin
          next_st.rdOut = st.readData;
          next_st.dataAvail = rdDataLoad;
          next_st.rdTaken = st.dataAvail;
        end
        `LGAP_OFS_CMD: begin
          next_st.rdOut = 8'h00;
          next_st.rdOut[`LGAP_FLAG_BIT] = !st.cmdBusy;
        end
        `LGAP_OFS_AVAIL: begin
          next_st.rdOut = 8'h00;
          next_st.rdOut[`LGAP_FLAG_BIT] = st.dataAvail;
        end
        default: next_st.rdOut = `LGAP_IDLE_READ;
      endcase
    end

    // interface reset drops pending command and data
    if (st.ifReset) begin
      next_st.cmd = '0;
      next_st.cmdBusy = 1'b0;
      next_st.dataAvail = rdDataLoad;
      next_st.mixIndex = 8'h00;
    end

    next_st.mode = otherCodecActive ? LGAP_MODE_OTHER : LGAP_MODE_LEGACY;
    next_st.irq = codecIrqReq;
    next_st.dma = codecDmaReq;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.rstState <= LGAP_RST_IDLE;
      st.mode <= LGAP_MODE_LEGACY;
    end else begin
      st <= next_st;
    end
  end

  // =====================================
  // outputs
  assign ioRdData = st.rdOut;
  assign ioRdValid = st.rdValid;
  assign fmReq = st.fm;
  assign cmdOut = st.cmd;
  assign rdDataTaken = st.rdTaken;
  assign legacyGameAudioMode = (st.mode == LGAP_MODE_LEGACY);
  assign sharedIrq = st.irq;
  assign sharedDmaReq = st.dma;
  assign mixerState = mixer;
  assign adcSource = lgap_src_e'(mixer.inSel[`LGAP_INSEL_LO+1:`LGAP_INSEL_LO]);
  assign stereoSelect = mixer.outCtl[`LGAP_STEREO_BIT];
  assign ifResetPulse = st.ifReset;

endmodule

// ### tb/lgap_regs_sva.sv
`timescale 1ns/10ps
// =====
// checker
module lgap_regs_sva
  import lgap_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host bus
  input wire logic [ADDR_W-1:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioWrData,
  input wire logic ioRdValid,
  input wire logic [9:0] legacyPortBase,
  input wire logic legacyEnable,
  // internal sides
  input wire lgap_fm_s fmReq,
  input wire lgap_req_s cmdOut,
  input wire logic cmdTaken,
  input wire logic otherCodecActive,
  input wire logic codecIrqReq,
  input wire logic legacyGameAudioMode,
  input wire logic sharedIrq,
  input wire lgap_mixer_s mixerState,
  input wire lgap_src_e adcSource,
  input wire logic stereoSelect,
  input wire logic ifResetPulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic hit;
  assign hit = legacyEnable && ioAddr[ADDR_W-1:10] == '0 && ioAddr[9:4] == legacyPortBase[9:4];
  sequence s_wr(ofs);
    ioWr && hit && ioAddr[3:0] == ofs;
  endsequence
  a_read_answer: assert property (ioRd && hit |=> ioRdValid)
    else $error("decoded read not answered");
  a_no_alias: assert property (ioRd && !hit |=> !ioRdValid)
    else $error("undecoded read answered");
  a_fm_forward: assert property (s_wr(4'h1) |=> fmReq.wr && fmReq.port == 2'h1
    && !fmReq.legacySel && fmReq.data == $past(ioWrData)) else $error("synth write lost");
  a_cmd_hold: assert property (cmdOut.valid && !cmdTaken && !ifResetPulse |=> cmdOut.valid)
    else $error("command dropped early");
  a_cmd_take: assert property (s_wr(4'hC) ##0 (!cmdOut.valid && !ifResetPulse) |=> cmdOut.valid
    && cmdOut.data == $past(ioWrData)) else $error("command not taken");
  a_reset_defaults: assert property (ifResetPulse |=> mixerState == 64'h9901000099990101)
    else $error("mixer not restored");
  a_adc_source: assert property (adcSource == mixerState.inSel[2:1])
    else $error("source select wrong");
  a_stereo_bit: assert property (stereoSelect == mixerState.outCtl[1])
    else $error("stereo select wrong");
  a_mode_follow: assert property (1 |=> legacyGameAudioMode == !$past(otherCodecActive))
    else $error("mode not followed");
  a_irq_share: assert property (1 |=> sharedIrq == $past(codecIrqReq))
    else $error("shared irq wrong");
endmodule

bind lgap_regs lgap_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.clk, .rst_n, .ioAddr, .ioRd, .ioWr,
  .ioWrData, .ioRdValid, .legacyPortBase, .legacyEnable, .fmReq, .cmdOut, .cmdTaken,
  .otherCodecActive, .codecIrqReq, .legacyGameAudioMode, .sharedIrq, .mixerState, .adcSource,
  .stereoSelect, .ifResetPulse);

// ### tb/lgap_engine_model.sv
`timescale 1ns/10ps
// =====
// command engine model
module lgap_engine_model
  import lgap_pkg::*;
#(
  parameter int DELAY = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command side
  input wire lgap_req_s cmdOut,
  output logic cmdTaken,
  output logic rdDataLoad,
  output logic [7:0] rdDataIn
);
  int waitCnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 0;
      cmdTaken <= 1'b0;
      rdDataLoad <= 1'b0;
      rdDataIn <= 8'h00;
    end else begin
      cmdTaken <= 1'b0;
      rdDataLoad <= cmdTaken;
      // data line toggles whenever cmdTaken is low, except on taking a command, when it loads ~cmdOut.data
      if (!cmdTaken) begin
        rdDataIn <= ~rdDataIn;
      end
      if (cmdOut.valid && !cmdTaken) begin
        if (waitCnt == DELAY) begin
          cmdTaken <= 1'b1;
          waitCnt <= 0;
          rdDataIn <= ~cmdOut.data;
        end else begin
          waitCnt <= waitCnt + 1;
        end
      end
    end
  end
endmodule

// ### tb/legacy_game_audio_port_regs_tb.sv
`timescale 1ns/10ps
// =====
// bench
module legacy_game_audio_port_regs_tb import lgap_pkg::*;;
  localparam logic [9:0] BASE = 10'h220;
  localparam logic [7:0] IDX [8] = '{8'h04, 8'h0A, 8'h0C, 8'h0E, 8'h22, 8'h26, 8'h28, 8'h2E};
  localparam logic [7:0] DEF [8] = '{8'h99, 8'h01, 8'h00, 8'h00, 8'h99, 8'h99, 8'h01, 8'h01};
  localparam logic [7:0] VAL [8] = '{8'h91, 8'h03, 8'h06, 8'h02, 8'h19, 8'h91, 8'h99, 8'h10};
  logic clk = 1'b0, rst_n = 1'b0, ioRd = 1'b0, ioWr = 1'b0, legacyEnable = 1'b1;
  logic otherCodecActive = 1'b0, codecIrqReq = 1'b0, codecDmaReq = 1'b0;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0] ioWrData = 8'h00, fmStatus = 8'h3C, ioRdData, rdDataIn, rdv;
  logic [9:0] legacyPortBase = BASE;
  logic ioRdValid, cmdTaken, rdDataLoad, rdDataTaken, legacyGameAudioMode, sharedIrq;
  logic sharedDmaReq, stereoSelect, ifResetPulse, vld;
  lgap_fm_s fmReq;
  lgap_req_s cmdOut;
  lgap_mixer_s mixerState;
  lgap_src_e adcSource;
  int num_errors = 0, comparisons = 0, cycles = 0;

  lgap_regs dut (.clk, .rst_n, .ioAddr, .ioRd, .ioWr, .ioWrData, .ioRdData, .ioRdValid,
    .legacyPortBase, .legacyEnable, .fmReq, .fmStatus, .cmdOut, .cmdTaken, .rdDataLoad,
    .rdDataIn, .rdDataTaken, .otherCodecActive, .codecIrqReq, .codecDmaReq,
    .legacyGameAudioMode, .sharedIrq, .sharedDmaReq, .mixerState, .adcSource,
    .stereoSelect, .ifResetPulse);
  lgap_engine_model #(.DELAY(4)) partner (.clk, .rst_n, .cmdOut, .cmdTaken, .rdDataLoad,
    .rdDataIn);

  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one strobe cycle, result sampled after the answering edge
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    ioAddr <= a;
    ioWr <= w;
    ioRd <= !w;
    ioWrData <= d;
    @(posedge clk);
    ioWr <= 1'b0;
    ioRd <= 1'b0;
    #1 vld = ioRdValid;
    rdv = ioRdData;
  endtask

  task automatic wr(input logic [3:0] o, input logic [7:0] d);
    acc({6'h00, BASE[9:4], o}, 1'b1, d);
  endtask

  task automatic rd(input logic [3:0] o);
    acc({6'h00, BASE[9:4], o}, 1'b0, 8'h00);
  endtask

  task automatic chk_mix(input logic [7:0] e [8]);
    for (int i = 0; i < 8; i++) begin
      wr(4'h4, IDX[i]);
      rd(4'h5);
      chk(rdv, e[i]);
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_mix(DEF);
    for (int i = 0; i < 8; i++) begin
      wr(4'h4, IDX[i]);
      wr(4'h5, VAL[i]);
    end
    chk_mix(VAL);
    chk({7'h00, stereoSelect}, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(4'h4, 8'h0C);
      wr(4'h5, 8'(c << 1));
      chk({6'h00, adcSource}, 8'(c));
    end
    wr(4'h4, 8'h02);
    wr(4'h5, 8'h55);
    rd(4'h5);
    chk(rdv, 8'hFF);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h5A);
    chk_mix(DEF);
    acc({6'h01, BASE[9:4], 4'hE}, 1'b0, 8'h00);
    chk({7'h00, vld}, 8'h00);
    acc({6'h00, BASE[9:4] + 6'h01, 4'h0}, 1'b0, 8'h00);
    chk({7'h00, vld}, 8'h00);
    wr(4'h1, 8'hA7);
    chk(fmReq.data, 8'hA7);
    chk({4'h0, fmReq.legacySel, fmReq.wr, fmReq.port}, 8'h05);
    wr(4'h9, 8'h4E);
    chk({4'h0, fmReq.legacySel, fmReq.wr, fmReq.port}, 8'h0D);
    rd(4'h0);
    chk(rdv, 8'h3C);
    chk({4'h0, fmReq.legacySel, fmReq.rd, fmReq.port}, 8'h04);
    rd(4'hC);
    chk({7'h00, rdv[7]}, 8'h01);
    wr(4'hC, 8'hA5);
    rd(4'hC);
    chk({7'h00, rdv[7]}, 8'h00);
    for (int n = 0; n < 20 && rdv[7] !== 1'b1; n++) rd(4'hE);
    chk({7'h00, rdv[7]}, 8'h01);
    rd(4'hA);
    chk(rdv, 8'h5A);
    chk({7'h00, rdDataTaken}, 8'h01);
    rd(4'hE);
    chk({7'h00, rdv[7]}, 8'h00);
    rd(4'hC);
    chk({7'h00, rdv[7]}, 8'h01);
    wr(4'h4, 8'h04);
    wr(4'h5, 8'h33);
    wr(4'h6, 8'h01);
    wr(4'h6, 8'h00);
    chk({7'h00, ifResetPulse}, 8'h01);
    chk_mix(DEF);
    @(posedge clk);
    otherCodecActive <= 1'b1;
    codecIrqReq <= 1'b1;
    codecDmaReq <= 1'b1;
    @(posedge clk);
    #1 chk({5'h00, legacyGameAudioMode, sharedIrq, sharedDmaReq}, 8'h03);
    give_verdict();
  end
endmodule
